// >>> hdl/edc_pkg.sv
// package of constants for the edo dram host controller
package edc_pkg;
  localparam int unsigned CLK_MHZ = 50;
  // power-up pause and init cycles
  localparam int unsigned INIT_PAUSE_US = 200;
  localparam int unsigned INIT_PAUSE_CYC = INIT_PAUSE_US * CLK_MHZ;
  localparam int unsigned INIT_CYCLES = 8;
  // refresh interval and row count
  localparam int unsigned REF_PERIOD_MS = 16;
  localparam int unsigned REF_ROWS = 1024;
  localparam int unsigned REF_INTERVAL_CYC = (REF_PERIOD_MS * 1000 * CLK_MHZ) / REF_ROWS;
  // strobe phase lengths in clock cycles
  localparam int unsigned ROW_ACTIVE_CYC = 3;
  localparam int unsigned PRECHARGE_CYC = 2;
  localparam int unsigned COL_PHASE_CYC = 2;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_RMW = 2'h2;
endpackage

// >>> hdl/edc_timer.sv
// down counter that raises done when a loaded count expires and holds it at zero
`timescale 1ns/100ps
`default_nettype none
module edc_timer #(
  parameter int W = 16
) (
  input wire logic mclk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic load, // load a new count
  input wire logic [W-1:0] value, // cycles to wait
  output logic done // high while count is zero
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  // count down to zero and hold there
  always_comb begin
    next_cnt = cnt;
    if (load) begin
      next_cnt = value;
    end else if (cnt != '0) begin
      next_cnt = cnt - W'(1);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
  assign done = (cnt == '0);
endmodule // edc_timer
`default_nettype wire

// >>> hdl/edc_ctrl.sv
// host controller driving an asynchronous x16 edo dram through its pins
`timescale 1ns/100ps
`default_nettype none
module edc_ctrl #(
  parameter int unsigned INIT_PAUSE = edc_pkg::INIT_PAUSE_CYC,
  parameter int unsigned REF_INTERVAL = edc_pkg::REF_INTERVAL_CYC
) (
  input wire logic mclk, // 50 mhz clock
  input wire logic rst_n, // async reset, active low
  input wire logic req_valid, // access request
  input wire logic [1:0] req_op, // read, write or read-write
  input wire logic [9:0] req_row, // row address
  input wire logic [9:0] req_col, // column address
  input wire logic [1:0] req_be, // byte lanes, bit1 high byte
  input wire logic [15:0] req_wdata, // write data
  input wire logic req_page, // keep row open for next request
  output logic req_ready, // request taken this cycle
  output logic rsp_valid, // read data pulse
  output logic [15:0] rsp_rdata, // read data
  output logic init_done, // initialization complete
  output logic [9:0] mux_addr_pins, // multiplexed address
  output logic row_strobe_n, // row strobe
  output logic low_byte_col_strobe_n, // low lane column strobe
  output logic high_byte_col_strobe_n, // high lane column strobe
  output logic write_en_n, // write enable
  output logic out_en_n, // output enable
  output logic [15:0] data_pins_o, // data driven to device
  output logic data_pins_oe, // high while we drive data
  input wire logic [15:0] data_pins_i // data from device
);
  typedef enum {ST_PAUSE, ST_INIT_RAS, ST_INIT_PRE, ST_IDLE, ST_ROW, ST_COL, ST_RW2,
    ST_COLUP, ST_REF_CAS, ST_REF_RAS, ST_PRE} edc_state_t;
  edc_state_t state, next_state;
  logic [3:0] init_cnt, next_init_cnt;
  logic [19:0] ref_cnt, next_ref_cnt;
  logic ref_due, next_ref_due;
  logic [1:0] op, next_op;
  logic [9:0] col, next_col;
  logic [9:0] row, next_row; // row held open for page compares
  logic [1:0] be, next_be;
  logic [15:0] wdata, next_wdata;
  logic page, next_page;
  logic next_ready, next_rsp_valid, next_init_done;
  logic [15:0] next_rdata, next_dout;
  logic [9:0] next_addr;
  logic next_ras, next_low_byte_col_strobe_n, next_high_byte_col_strobe_n, next_we, next_oe, next_doe;
  logic t_load, t_done;
  logic pause_seen; // pause count has been armed
  logic [19:0] t_val;
  edc_timer #(.W(20)) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(t_load),
    .value(t_val),
    .done(t_done)
  );
  // lane strobes from byte enables: low bit is the low byte lane
  function automatic logic [1:0] lane_n(input logic [1:0] b);
    return ~b;
  endfunction
  // refresh tick: rows spread evenly across the period
  always_comb begin
    next_ref_cnt = ref_cnt + 20'h1;
    next_ref_due = ref_due;
    if (ref_cnt >= 20'(REF_INTERVAL - 1)) begin
      next_ref_cnt = 20'h0;
      next_ref_due = 1'b1;
    end
    if (state == edc_state_t'(ST_REF_RAS) && t_done) begin
      next_ref_due = next_ref_cnt == 20'h0;
    end
  end
  // main sequencer
  always_comb begin
    next_state = state;
    next_init_cnt = init_cnt;
    next_op = op;
    next_col = col;
    next_row = row;
    next_be = be;
    next_wdata = wdata;
    next_page = page;
    next_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_init_done = init_done;
    next_rdata = rsp_rdata;
    next_dout = data_pins_o;
    next_addr = mux_addr_pins;
    next_ras = row_strobe_n;
    next_low_byte_col_strobe_n = low_byte_col_strobe_n;
    next_high_byte_col_strobe_n = high_byte_col_strobe_n;
    next_we = write_en_n;
    next_oe = out_en_n;
    next_doe = data_pins_oe;
    t_load = 1'b0;
    t_val = 20'h0;
    unique case (state)
      ST_PAUSE: begin
        // strobes high during pause; first cycle arms the pause count
        if (!pause_seen) begin
          t_load = 1'b1;
          t_val = 20'(INIT_PAUSE);
        end else if (t_done) begin
          next_state = ST_INIT_RAS;
          next_ras = 1'b0;
          t_load = 1'b1;
          t_val = 20'(edc_pkg::ROW_ACTIVE_CYC);
        end
      end
      ST_INIT_RAS: begin
        if (t_done) begin
          next_ras = 1'b1;
          next_init_cnt = init_cnt + 4'h1;
          next_state = ST_INIT_PRE;
          t_load = 1'b1;
          t_val = 20'(edc_pkg::PRECHARGE_CYC);
        end
      end
      ST_INIT_PRE: begin
        if (t_done) begin
          if (init_cnt == 4'(edc_pkg::INIT_CYCLES)) begin
            next_init_done = 1'b1;
            next_state = ST_IDLE;
          end else begin
            next_ras = 1'b0;
            next_state = ST_INIT_RAS;
            t_load = 1'b1;
            t_val = 20'(edc_pkg::ROW_ACTIVE_CYC);
          end
        end
      end
      ST_IDLE: begin
        if (ref_due) begin
          // column strobes low before row strobe
          // write enable high, both lanes active
          next_low_byte_col_strobe_n = 1'b0;
          next_high_byte_col_strobe_n = 1'b0;
          next_we = 1'b1;
          next_oe = 1'b1;
          next_doe = 1'b0;
          next_state = ST_REF_CAS;
        end else if (req_valid) begin
          // row address set before row strobe falls
          next_ready = 1'b1;
          next_op = req_op;
          next_col = req_col;
          next_row = req_row;
          next_be = req_be;
          next_wdata = req_wdata;
          next_page = req_page;
          next_addr = req_row;
          next_state = ST_ROW;
        end
      end
      ST_ROW: begin
        // row latched here is refreshed by the access
        next_ras = 1'b0;
        next_state = ST_COL;
        next_addr = col;
        t_load = 1'b1;
        t_val = 20'(edc_pkg::COL_PHASE_CYC);
        // data driven in the same cycle as write enable, before the column strobes
        next_dout = wdata;
        next_doe = op == edc_pkg::OP_WRITE;
        next_we = op != edc_pkg::OP_WRITE;
        // output enable low so column strobe edge starts read
        next_oe = op == edc_pkg::OP_WRITE;
      end
      ST_COL: begin
        // byte lanes chosen by column strobes
        {next_high_byte_col_strobe_n, next_low_byte_col_strobe_n} = lane_n(be);
        if (t_done && !low_byte_col_strobe_n | !high_byte_col_strobe_n) begin
          // data sampled after the access delay
          next_rdata = data_pins_i;
          next_rsp_valid = op != edc_pkg::OP_WRITE;
          if (op == edc_pkg::OP_RMW) begin
            // output off, then write in same column cycle
            next_oe = 1'b1;
            next_state = ST_RW2;
            t_load = 1'b1;
            t_val = 20'(edc_pkg::COL_PHASE_CYC);
          end else begin
            next_state = ST_COLUP;
            // page: hold the row a little so the next request can arrive
            t_load = page;
            t_val = 20'(2 * edc_pkg::COL_PHASE_CYC);
          end
        end
      end
      ST_RW2: begin
        next_doe = 1'b1;
        // write starts at late write enable fall
        next_we = !data_pins_oe;
        if (t_done && data_pins_oe && !write_en_n) begin
          next_state = ST_COLUP;
        end
      end
      ST_COLUP: begin
        next_low_byte_col_strobe_n = 1'b1;
        next_high_byte_col_strobe_n = 1'b1;
        next_we = 1'b1;
        next_doe = 1'b0;
        // page mode: next column, row stays low
        // device holds read data to next column fall
        if (page && req_valid && req_row == row && t_done) begin
          next_ready = 1'b1;
          next_op = req_op;
          next_col = req_col;
          next_be = req_be;
          next_wdata = req_wdata;
          next_page = req_page;
          next_state = ST_ROW;
        end else if (t_done) begin
          // cycle ends with all strobes high
          next_ras = 1'b1;
          next_oe = 1'b1;
          next_state = ST_PRE;
          t_load = 1'b1;
          t_val = 20'(edc_pkg::PRECHARGE_CYC);
        end
      end
      ST_REF_CAS: begin
        // address pins are don't care here
        next_ras = 1'b0;
        next_state = ST_REF_RAS;
        t_load = 1'b1;
        t_val = 20'(edc_pkg::ROW_ACTIVE_CYC);
      end
      ST_REF_RAS: begin
        // data pins left released during refresh
        if (t_done) begin
          next_ras = 1'b1;
          next_low_byte_col_strobe_n = 1'b1;
          next_high_byte_col_strobe_n = 1'b1;
          next_state = ST_PRE;
          t_load = 1'b1;
          t_val = 20'(edc_pkg::PRECHARGE_CYC);
        end
      end
      ST_PRE: begin
        if (t_done) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end
  // hidden refresh not issued; row-only used for init only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_PAUSE;
      init_cnt <= 4'h0;
      ref_cnt <= 20'h0;
      ref_due <= 1'b0;
      op <= 2'h0;
      col <= 10'h0;
      row <= 10'h0;
      be <= 2'h0;
      wdata <= 16'h0;
      page <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0;
      init_done <= 1'b0;
      mux_addr_pins <= 10'h0;
      row_strobe_n <= 1'b1;
      low_byte_col_strobe_n <= 1'b1;
      high_byte_col_strobe_n <= 1'b1;
      write_en_n <= 1'b1;
      out_en_n <= 1'b1;
      data_pins_o <= 16'h0;
      data_pins_oe <= 1'b0;
    end else begin
      state <= next_state;
      init_cnt <= next_init_cnt;
      ref_cnt <= next_ref_cnt;
      ref_due <= next_ref_due;
      op <= next_op;
      col <= next_col;
      row <= next_row;
      be <= next_be;
      wdata <= next_wdata;
      page <= next_page;
      req_ready <= next_ready;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rdata;
      init_done <= next_init_done;
      mux_addr_pins <= next_addr;
      row_strobe_n <= next_ras;
      low_byte_col_strobe_n <= next_low_byte_col_strobe_n;
      high_byte_col_strobe_n <= next_high_byte_col_strobe_n;
      write_en_n <= next_we;
      out_en_n <= next_oe;
      data_pins_o <= next_dout;
      data_pins_oe <= next_doe;
    end
  end
  // pause ends only after the full count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pause_seen <= 1'b0;
    end else if (state == ST_PAUSE) begin
      pause_seen <= 1'b1;
    end
  end
  no_early_req_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req_ready |-> init_done) else $error("request taken before init");
  ref_hiz_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == ST_REF_RAS) |-> !data_pins_oe) else $error("data driven during refresh");
  // column strobe leads row strobe in refresh
  cbr_order_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == ST_REF_CAS) |-> !low_byte_col_strobe_n && row_strobe_n)
    else $error("refresh order wrong");
  cbr_we_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == ST_REF_RAS) |-> write_en_n) else $error("write low in refresh");
  pause_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == ST_PAUSE) |-> row_strobe_n && write_en_n) else $error("strobe low in pause");
  // row strobe low for full active time
  ras_min_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(row_strobe_n) |-> !row_strobe_n [*3]) else $error("row active too short");
  lane_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state == ST_COL && !be[0]) |=> low_byte_col_strobe_n) else $error("wrong lane");
  // write data out no later than the cycle write enable falls
  wdata_early_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(write_en_n) |-> data_pins_oe) else $error("write data late");
  cov_read_c: cover property (@(posedge mclk) disable iff (!rst_n) rsp_valid);
  cov_ref_c: cover property (@(posedge mclk) disable iff (!rst_n) state == ST_REF_RAS);
  cov_rmw_c: cover property (@(posedge mclk) disable iff (!rst_n) state == ST_RW2);
  cov_init_c: cover property (@(posedge mclk) disable iff (!rst_n) $rose(init_done) && pause_seen);
endmodule // edc_ctrl
`default_nettype wire

// >>> verification/edc_dram_model.sv
// behavioural x16 dram model on the far side of the host controller
`timescale 1ns/100ps
`default_nettype none
module edc_dram_model (
  input wire logic mclk, // paces the released-bus pattern only
  input wire logic [9:0] addr, // multiplexed address
  input wire logic row_n, // row strobe
  input wire logic lo_n, // low lane column strobe
  input wire logic hi_n, // high lane column strobe
  input wire logic we_n, // write enable
  input wire logic oe_n, // output enable
  input wire logic [15:0] dq_o, // host data
  input wire logic dq_oe, // host drives the bus
  output logic [15:0] dq, // resolved bus level
  output var int falls, // row strobe falls
  output var int refs, // refresh cycles seen
  output var int viol // host faults seen
);
  logic [15:0] mem [bit [19:0]];
  logic [9:0] row;
  logic [9:0] col;
  logic [8:0] rctr;
  logic [15:0] dout;
  logic [15:0] w;
  logic [15:0] last;
  logic [1:0] rd;
  logic refr;
  logic cas_on;
  realtime t_fall;
  realtime t_rise;
  wire cas_n;
  initial begin
    {falls, refs, viol} = '0;
    {rd, refr, cas_on, rctr} = '0;
    last = 16'h0000;
  end
  // internal strobe, first fall to last rise
  assign cas_n = lo_n & hi_n;
  always @(negedge row_n) begin
    falls++;
    if (falls > 1 && $realtime - t_rise < edc_pkg::PRECHARGE_CYC * 20.0) viol++;
    t_fall = $realtime;
    refr = !cas_n;
    if (refr) begin
      refs++;
      rctr = rctr + 9'h001; // pins ignored, counter picks the row
      if (!we_n) viol++;
    end else begin
      row = addr;
    end
  end
  // row active time before the cycle ends
  always @(posedge row_n) begin
    if (falls > 0 && $realtime - t_fall < edc_pkg::ROW_ACTIVE_CYC * 20.0) viol++;
    t_rise = $realtime;
  end
  // column latch, read launch, lane writes
  always @(negedge lo_n or negedge hi_n or negedge we_n) begin
    if (!cas_on && !cas_n && !row_n && !refr) begin
      col = addr;
      if (falls < 9) viol++;
      dout = mem.exists({row, col}) ? mem[{row, col}] : 16'h0000;
      rd = {~hi_n, ~lo_n} & {2{we_n}};
    end
    cas_on = cas_on | ~cas_n;
    if (!row_n && !refr && !we_n && !cas_n) begin
      if (!dq_oe) viol++;
      w = mem.exists({row, col}) ? mem[{row, col}] : 16'h0000;
      if (!lo_n) w[7:0] = dq_o[7:0];
      if (!hi_n) w[15:8] = dq_o[15:8];
      mem[{row, col}] = w;
    end
  end
  // data held until every strobe is high
  always @(posedge lo_n or posedge hi_n or posedge row_n) begin
    if (cas_n) cas_on = 1'b0;
    if (cas_n && row_n) rd = 2'b00;
  end
  // lane drive; a released lane toggles so stale data never matches
  assign dq[7:0] = dq_oe ? dq_o[7:0] : (rd[0] && !oe_n && we_n) ? dout[7:0] : ~last[7:0];
  assign dq[15:8] = dq_oe ? dq_o[15:8] : (rd[1] && !oe_n && we_n) ? dout[15:8] : ~last[15:8];
  always @(posedge mclk) last <= dq;
endmodule // edc_dram_model
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the x16 dram host controller
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int unsigned PAUSE = 20;
  localparam int unsigned REF = 50;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic [1:0] req_op = 2'h0;
  logic [9:0] req_row = 10'h000;
  logic [9:0] req_col = 10'h000;
  logic [1:0] req_be = 2'h0;
  logic [15:0] req_wdata = 16'h0000;
  logic req_page = 1'b0;
  logic req_ready, rsp_valid, init_done, row_n, lo_n, hi_n, we_n, oe_n, dq_oe;
  logic [15:0] rsp_rdata, dq_o, dq;
  logic [9:0] addr;
  int fails = 0;
  int n_tests = 0;
  int falls, refs, viol;
  logic [15:0] q;
  always #10 mclk = ~mclk;
  edc_ctrl #(.INIT_PAUSE(PAUSE), .REF_INTERVAL(REF)) DUT (.mclk(mclk), .rst_n(rst_n),
    .req_valid(req_valid), .req_op(req_op), .req_row(req_row), .req_col(req_col),
    .req_be(req_be), .req_wdata(req_wdata), .req_page(req_page), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done),
    .mux_addr_pins(addr), .row_strobe_n(row_n), .low_byte_col_strobe_n(lo_n),
    .high_byte_col_strobe_n(hi_n), .write_en_n(we_n), .out_en_n(oe_n),
    .data_pins_o(dq_o), .data_pins_oe(dq_oe), .data_pins_i(dq));
  edc_dram_model far_end (.mclk(mclk), .addr(addr), .row_n(row_n), .lo_n(lo_n),
    .hi_n(hi_n), .we_n(we_n), .oe_n(oe_n), .dq_o(dq_o), .dq_oe(dq_oe), .dq(dq),
    .falls(falls), .refs(refs), .viol(viol));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one request held until taken; reads also wait for the answer pulse
  task automatic req(input logic [1:0] op, input logic [9:0] r, input logic [9:0] c,
                     input logic [1:0] be, input logic [15:0] wd, input logic pg);
    int n;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op <= op;
    req_row <= r;
    req_col <= c;
    req_be <= be;
    req_wdata <= wd;
    req_page <= pg;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (req_ready !== 1'b1 && n < 300);
    req_valid <= 1'b0;
    check("req_ready", req_ready, 1'b1);
    if (op != edc_pkg::OP_WRITE) begin
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (rsp_valid !== 1'b1 && n < 30);
      check("rsp_valid", rsp_valid, 1'b1);
      q = rsp_rdata;
    end
  endtask
  task automatic wr(input logic [9:0] r, input logic [9:0] c, input logic [1:0] be,
                    input logic [15:0] wd, input logic pg);
    req(edc_pkg::OP_WRITE, r, c, be, wd, pg);
  endtask
  task automatic rdw(input logic [9:0] r, input logic [9:0] c, input logic [1:0] be,
                     input logic pg);
    req(edc_pkg::OP_READ, r, c, be, 16'h0000, pg);
  endtask
  // wait for a refresh so the next few requests see no refresh row cycle
  task automatic sync();
    int n;
    int c;
    c = refs;
    n = 0;
    while (refs == c && n < 300) begin
      @(posedge mclk);
      n++;
    end
    check("refresh seen", refs != c, 1'b1);
  endtask
  task automatic t_init();
    int n;
    check("row strobe in reset", row_n, 1'b1);
    check("bus driven in reset", dq_oe, 1'b0);
    @(posedge mclk);
    rst_n <= 1'b1;
    repeat (PAUSE - 2) @(posedge mclk);
    check("falls in pause", falls, 0);
    check("early init_done", init_done, 1'b0);
    n = 0;
    while (init_done !== 1'b1 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    check("init_done", init_done, 1'b1);
    check("init row cycles", falls >= 8, 1'b1);
  endtask
  // words at a low and the top row and column
  task automatic t_word();
    wr(10'h003, 10'h005, 2'h3, 16'ha55a, 1'b0);
    wr(10'h3ff, 10'h3ff, 2'h3, 16'h1234, 1'b0);
    rdw(10'h003, 10'h005, 2'h3, 1'b0);
    check("word low", q, 16'ha55a);
    rdw(10'h3ff, 10'h3ff, 2'h3, 1'b0);
    check("word top", q, 16'h1234);
  endtask
  // lane writes merge; lane reads return the enabled byte
  task automatic t_bytes();
    wr(10'h007, 10'h009, 2'h3, 16'h0000, 1'b0);
    wr(10'h007, 10'h009, 2'h1, 16'hff11, 1'b0);
    wr(10'h007, 10'h009, 2'h2, 16'h22ff, 1'b0);
    rdw(10'h007, 10'h009, 2'h3, 1'b0);
    check("merged lanes", q, 16'h2211);
    rdw(10'h007, 10'h009, 2'h1, 1'b0);
    check("low lane", q[7:0], 8'h11);
    rdw(10'h007, 10'h009, 2'h2, 1'b0);
    check("high lane", q[15:8], 8'h22);
  endtask
  task automatic t_rmw();
    req(edc_pkg::OP_RMW, 10'h007, 10'h009, 2'h3, 16'hbeef, 1'b0);
    check("read-write old", q, 16'h2211);
    rdw(10'h007, 10'h009, 2'h3, 1'b0);
    check("read-write new", q, 16'hbeef);
  endtask
  // page pairs open the row once
  task automatic t_page();
    int b;
    sync();
    b = falls;
    wr(10'h014, 10'h001, 2'h3, 16'h0101, 1'b1);
    wr(10'h014, 10'h002, 2'h3, 16'h0202, 1'b0);
    repeat (4) @(posedge mclk);
    check("page write rows", falls - b, 1);
    sync();
    b = falls;
    rdw(10'h014, 10'h001, 2'h3, 1'b1);
    check("page read 1", q, 16'h0101);
    rdw(10'h014, 10'h002, 2'h3, 1'b0);
    check("page read 2", q, 16'h0202);
    check("page read rows", falls - b, 1);
  endtask
  task automatic t_refresh();
    int b;
    b = refs;
    repeat (10 * REF) @(posedge mclk);
    check("refresh rate", refs - b >= 9, 1'b1);
    check("host faults", viol, 0);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    t_init();
    t_word();
    t_bytes();
    t_rmw();
    t_page();
    t_refresh();
    complete_run();
  end
  // hang guard, far beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    complete_run();
  end
endmodule // tb
`default_nettype wire
